/* File: dtp_cfg.svh */
`ifndef DTP_CFG_SVH
`define DTP_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DTP_OFS_MODE_CH0 6'h00
`define DTP_OFS_MODE_CH1 6'h04
`define DTP_OFS_DUTY_CH0 6'h08
`define DTP_OFS_CYCLE_CH0 6'h0c
`define DTP_OFS_DUTY_CH1 6'h10
`define DTP_OFS_HIGH_CH1 6'h14
`define DTP_OFS_PAIR_CTRL 6'h18
`define DTP_OFS_STATUS 6'h1c

// ----------------------------------------------------------------------
// Field values and positions
// ----------------------------------------------------------------------
`define DTP_MODE_PPG 2'h2
`define DTP_STAT_OUT0_BIT 16
`define DTP_STAT_OUT1_BIT 17

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DTP_RST_MODE 8'h00
`define DTP_RST_PAIR 4'h0
`define DTP_RST_CMP 8'h00
`define DTP_RST_CMP16 16'h0000

// ----------------------------------------------------------------------
// Timing counts (prescaler taps in source clock selections)
// ----------------------------------------------------------------------
`define DTP_PRESCALE_BITS 11

`endif

/* File: dtp_pkg.sv */
package dtp_pkg;

  // --------------------------------------------------------------------
  // Channel mode register layout
  // --------------------------------------------------------------------
  typedef struct packed {
    logic initial_level_select; // Idle level of the pulse output
    logic dbuf_enable;          // Double buffer for compare values
    logic [2:0] clock_sel;      // Source clock tap
    logic ext_input_sel;        // External count input, must be 0
    logic [1:0] mode_field;     // Operating mode
  } dtp_mode_type;

  // --------------------------------------------------------------------
  // Pair control register layout
  // --------------------------------------------------------------------
  typedef struct packed {
    logic and_output_select; // Pin shows AND of both outputs
    logic cascade_select;    // Join channels into 16-bit timer
    logic run_bit_ch1;       // Channel 1 run
    logic run_bit_ch0;       // Channel 0 run
  } dtp_pair_type;

endpackage

/* File: dtp_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtp_cfg.svh"

module dtp_timer #(
  parameter int PRESCALE_WIDTH = `DTP_PRESCALE_BITS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pulse_output_pin,
  output logic pulse_output_ch1,
  output logic irq_channel0,
  output logic irq_channel1
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if (PRESCALE_WIDTH < `DTP_PRESCALE_BITS) begin : g_bad_prescale
    $error("Prescaler too narrow for the slowest source clock");
  end

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  dtp_pkg::dtp_mode_type mode_reg [2]; // Per-channel mode registers
  dtp_pkg::dtp_pair_type pair_control_reg; // Shared run and pair bits
  logic [7:0] duty_buf [2];   // Last written duty values
  logic [7:0] duty_act [2];   // Duty values used for matching
  logic [7:0] cycle_buf [2];  // Last written cycle values
  logic [7:0] cycle_act [2];  // Cycle values used for matching
  logic [15:0] compare16_value; // Active 16-bit compare
  logic [7:0] cnt [2];        // Up counters, joined in cascade
  logic duty_done [2];        // Duty match already seen at this count
  logic cycle_done [2];       // Cycle match already seen at this count
  logic done16;               // 16-bit match seen at this count
  logic ppg_level [2];        // Toggled state, 0 means idle level
  logic [PRESCALE_WIDTH-1:0] prescale; // Free running divider

  // --------------------------------------------------------------------
  // Derived controls
  // --------------------------------------------------------------------
  logic do_write;       // Write takes effect this edge
  logic [7:0] wdata;    // Low byte of write data
  logic ppg_on [2];     // Channel runs as pulse generator
  logic cas_on;         // Cascade interval timer runs
  logic tick [2];       // Source clock enable per channel
  logic duty_hit [2];   // Duty match event
  logic cycle_hit [2];  // Cycle match event
  logic hit16;          // Cascade match event
  logic [7:0] next_cnt [2]; // Counter values for next edge
  logic wr_duty [2];    // Duty write strobes
  logic wr_cycle [2];   // Cycle write strobes
  logic [15:0] cnt16;   // Joined counter
  logic [15:0] next_cnt16; // Joined counter plus one

  // Source clock enable from the selected prescaler tap
  function automatic logic tap_tick(input logic [2:0] sel,
                                    input logic [PRESCALE_WIDTH-1:0] pre);
    logic r;
    r = 1'b0;
    case (sel)
      3'h0: r = &pre[10:0];
      3'h1: r = &pre[9:0];
      3'h2: r = &pre[7:0];
      3'h3: r = &pre[5:0];
      3'h4: r = &pre[3:0];
      3'h5: r = &pre[1:0];
      3'h6: r = pre[0];
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  // Answer one cycle after the request, then release for one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  assign do_write = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wdata = avs_writedata[7:0];

  // Write strobes for compare registers
  always_comb begin
    wr_duty[0] = do_write && (avs_address == `DTP_OFS_DUTY_CH0);
    wr_duty[1] = do_write && (avs_address == `DTP_OFS_DUTY_CH1);
    wr_cycle[0] = do_write && (avs_address == `DTP_OFS_CYCLE_CH0);
    wr_cycle[1] = do_write && (avs_address == `DTP_OFS_HIGH_CH1);
  end

  // Read data, loaded at the edge that drops waitrequest
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0;
      if (avs_address == `DTP_OFS_MODE_CH0) begin
        avs_readdata[7:0] <= mode_reg[0];
      end else if (avs_address == `DTP_OFS_MODE_CH1) begin
        avs_readdata[7:0] <= mode_reg[1];
      end else if (avs_address == `DTP_OFS_DUTY_CH0) begin
        avs_readdata[7:0] <= duty_buf[0];
      end else if (avs_address == `DTP_OFS_CYCLE_CH0) begin
        avs_readdata[7:0] <= cycle_buf[0];
      end else if (avs_address == `DTP_OFS_DUTY_CH1) begin
        avs_readdata[7:0] <= duty_buf[1];
      end else if (avs_address == `DTP_OFS_HIGH_CH1) begin
        avs_readdata[7:0] <= cycle_buf[1];
      end else if (avs_address == `DTP_OFS_PAIR_CTRL) begin
        avs_readdata[3:0] <= pair_control_reg;
      end else if (avs_address == `DTP_OFS_STATUS) begin
        avs_readdata[15:0] <= cnt16;
        avs_readdata[`DTP_STAT_OUT0_BIT] <= ppg_level[0];
        avs_readdata[`DTP_STAT_OUT1_BIT] <= ppg_level[1];
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  // Mode registers lock while their channel runs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_reg[0] <= `DTP_RST_MODE;
      mode_reg[1] <= `DTP_RST_MODE;
    end else begin
      if (do_write && avs_address == `DTP_OFS_MODE_CH0 &&
          !pair_control_reg.run_bit_ch0) begin
        mode_reg[0] <= wdata;
      end
      if (do_write && avs_address == `DTP_OFS_MODE_CH1 &&
          !pair_control_reg.run_bit_ch1) begin
        mode_reg[1] <= wdata;
      end
    end
  end

  // Pair control is always writable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair_control_reg <= `DTP_RST_PAIR;
    end else if (do_write && avs_address == `DTP_OFS_PAIR_CTRL) begin
      pair_control_reg <= wdata[3:0];
    end
  end

  // Free running prescaler for source clock taps
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Match detection
  // --------------------------------------------------------------------
  assign cnt16 = {cnt[1], cnt[0]};
  assign next_cnt16 = cnt16 + 16'h0001;

  always_comb begin
    // Cascade uses only channel 1 settings
    cas_on = pair_control_reg.cascade_select &&
             !mode_reg[1].mode_field[1] && !mode_reg[1].ext_input_sel &&
             pair_control_reg.run_bit_ch1;
    ppg_on[0] = !pair_control_reg.cascade_select &&
                mode_reg[0].mode_field == `DTP_MODE_PPG &&
                !mode_reg[0].ext_input_sel &&
                pair_control_reg.run_bit_ch0;
    ppg_on[1] = !pair_control_reg.cascade_select &&
                mode_reg[1].mode_field == `DTP_MODE_PPG &&
                !mode_reg[1].ext_input_sel &&
                pair_control_reg.run_bit_ch1;
    hit16 = cas_on && cnt16 == compare16_value && !done16;
    for (int c = 0; c < 2; c++) begin
      tick[c] = tap_tick(mode_reg[c].clock_sel, prescale);
      // Level compare, so an equal write matches next edge
      duty_hit[c] = ppg_on[c] && cnt[c] == duty_act[c] &&
                    !duty_done[c];
      cycle_hit[c] = ppg_on[c] && cnt[c] == cycle_act[c] &&
                     !cycle_done[c];
      // Counter next value
      if (cas_on) begin
        if (hit16) begin
          next_cnt[c] = 8'h00;
        end else if (tick[1]) begin
          next_cnt[c] = c == 0 ? next_cnt16[7:0] : next_cnt16[15:8];
        end else begin
          next_cnt[c] = cnt[c];
        end
      end else if (!ppg_on[c]) begin
        next_cnt[c] = 8'h00;
      end else if (cycle_hit[c]) begin
        next_cnt[c] = 8'h00;
      end else if (tick[c]) begin
        next_cnt[c] = cnt[c] + 8'h01;
      end else begin
        next_cnt[c] = cnt[c];
      end
    end
  end

  // Counters and per-count match memory
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        cnt[c] <= 8'h00;
        duty_done[c] <= 1'b0;
        cycle_done[c] <= 1'b0;
      end
      done16 <= 1'b0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        cnt[c] <= next_cnt[c];
        if (next_cnt[c] != cnt[c] || wr_duty[c]) begin
          duty_done[c] <= 1'b0;
        end else if (duty_hit[c]) begin
          duty_done[c] <= 1'b1;
        end
        if (next_cnt[c] != cnt[c] || wr_cycle[c]) begin
          cycle_done[c] <= 1'b0;
        end else if (cycle_hit[c]) begin
          cycle_done[c] <= 1'b1;
        end
      end
      if ({next_cnt[1], next_cnt[0]} != cnt16 || wr_cycle[1]) begin
        done16 <= 1'b0;
      end else if (hit16) begin
        done16 <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Compare registers
  // --------------------------------------------------------------------
  // Buffer always holds last write; active follows buffer rules
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < 2; c++) begin
        duty_buf[c] <= `DTP_RST_CMP;
        duty_act[c] <= `DTP_RST_CMP;
        cycle_buf[c] <= `DTP_RST_CMP;
        cycle_act[c] <= `DTP_RST_CMP;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_duty[c]) begin
          duty_buf[c] <= wdata;
        end
        if (wr_cycle[c]) begin
          cycle_buf[c] <= wdata;
        end
        if (mode_reg[c].dbuf_enable && ppg_on[c]) begin
          // Buffered while running: load on interrupt
          if (cycle_hit[c]) begin
            duty_act[c] <= duty_buf[c];
            cycle_act[c] <= cycle_buf[c];
          end
        end else if (!pair_control_reg.cascade_select) begin
          if (wr_duty[c]) begin
            duty_act[c] <= wdata;
          end
          if (wr_cycle[c]) begin
            cycle_act[c] <= wdata;
          end
        end
      end
    end
  end

  // 16-bit compare commits on the high byte write, or on the 16-bit match when buffered and running
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      compare16_value <= `DTP_RST_CMP16;
    end else if (mode_reg[1].dbuf_enable && cas_on) begin
      if (hit16) begin
        compare16_value <= {cycle_buf[1], cycle_buf[0]};
      end
    end else if (wr_cycle[1]) begin
      compare16_value <= {wdata, cycle_buf[0]};
    end
  end

  // --------------------------------------------------------------------
  // Pulse outputs and interrupts
  // --------------------------------------------------------------------
  // Toggle state: duty match leaves idle, cycle match returns
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ppg_level[0] <= 1'b0;
      ppg_level[1] <= 1'b0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!ppg_on[c]) begin
          ppg_level[c] <= 1'b0;
        end else if (cycle_hit[c]) begin
          ppg_level[c] <= 1'b0;
        end else if (duty_hit[c]) begin
          ppg_level[c] <= 1'b1;
        end
      end
    end
  end

  // Pin levels are idle level xor toggle state, optionally ANDed
  always_ff @(posedge sys_clk) begin
    logic out0;
    logic out1;
    out0 = 1'b0;
    out1 = 1'b0;
    if (sys_rst) begin
      pulse_output_pin <= 1'b0;
      pulse_output_ch1 <= 1'b0;
    end else begin
      out0 = mode_reg[0].initial_level_select ^ ppg_level[0];
      out1 = mode_reg[1].initial_level_select ^ ppg_level[1];
      if (pair_control_reg.and_output_select) begin
        pulse_output_pin <= out0 & out1;
      end else begin
        pulse_output_pin <= out0;
      end
      pulse_output_ch1 <= out1;
    end
  end

  // One-cycle interrupt requests
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_channel0 <= 1'b0;
      irq_channel1 <= 1'b0;
    end else begin
      irq_channel0 <= cycle_hit[0];
      irq_channel1 <= cycle_hit[1] || hit16;
    end
  end

endmodule
`default_nettype wire

/* File: dtp_timer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Port checker for the dual timer
// --------------------------------------------------------------
module dtp_timer_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pulse_output_pin,
  input wire logic pulse_output_ch1,
  input wire logic irq_channel0,
  input wire logic irq_channel1
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] pair; // Shadow of pair control
  logic [1:0] lvl; // Shadow of idle levels
  logic [2:0] quiet; // Stopped cycles since last write
  logic wr_ok; // Write lands at this edge
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Shadow follows accepted writes; mode ignored while running
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair <= 4'h0;
      lvl <= 2'h0;
    end else if (wr_ok) begin
      if (avs_address == 6'h18) pair <= avs_writedata[3:0];
      if (avs_address == 6'h00 && !pair[0]) lvl[0] <= avs_writedata[7];
      if (avs_address == 6'h04 && !pair[1]) lvl[1] <= avs_writedata[7];
    end
  end
  // Counts settled stopped cycles
  always_ff @(posedge sys_clk) begin
    if (sys_rst || wr_ok || pair[1:0] != 2'h0) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  a_wait_one_low: assert property (
    $fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_req_answered: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_irq0_single: assert property (irq_channel0 |=> !irq_channel0)
    else $error("channel 0 interrupt longer than one cycle");
  a_irq1_single: assert property (irq_channel1 |=> !irq_channel1)
    else $error("channel 1 interrupt longer than one cycle");
  // Interrupt follows a match seen while the run bit stood
  a_irq0_when_run: assert property (
    irq_channel0 |-> $past(pair[0]) && !$past(pair[2]))
    else $error("channel 0 interrupt while stopped or joined");
  a_irq1_when_run: assert property (
    irq_channel1 |-> $past(pair[1]))
    else $error("channel 1 interrupt while stopped");
  a_pin_idle_level: assert property (
    quiet == 3'h7 && !pair[2] |->
    pulse_output_pin == (pair[3] ? &lvl : lvl[0]))
    else $error("stopped pin not at idle level");
  a_ch1_idle_level: assert property (
    quiet == 3'h7 && !pair[2] |-> pulse_output_ch1 == lvl[1])
    else $error("stopped channel 1 output not at idle level");
  c_irq0: cover property (irq_channel0);
  c_irq1: cover property (irq_channel1 && pair[2]);
  c_and_high: cover property (pair[3] && pulse_output_pin);
endmodule
bind dtp_timer dtp_timer_chk i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pulse_output_pin(pulse_output_pin), .pulse_output_ch1(pulse_output_ch1),
  .irq_channel0(irq_channel0), .irq_channel1(irq_channel1));
`default_nettype wire

/* File: dtp_load.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Load on the pulse pin: measures high and low widths
// --------------------------------------------------------------
module dtp_load (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic level,
  output int high_w,
  output int low_w
);
  int run_len; // Cycles at the present level
  logic last; // Level seen last cycle
  // Store the length of each finished level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_len <= 1;
      last <= 1'b0;
    end else if (level != last) begin
      if (last) high_w <= run_len;
      else low_w <= run_len;
      run_len <= 1;
      last <= level;
    end else begin
      run_len <= run_len + 1;
    end
  end
endmodule
`default_nettype wire

/* File: dual_timer_ppg_and_cascade16_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_timer_ppg_and_cascade16_tb;
  logic sys_clk = 1'b0; // 20 MHz
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pulse_output_pin;
  logic pulse_output_ch1;
  logic [1:0] irq; // Both interrupts
  logic [31:0] rd; // Last read data
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int high_w;
  int low_w;
  int n_irq[2] = '{0, 0};
  int last_t[2] = '{0, 0};
  int prev_t[2] = '{0, 0};
  always #25 sys_clk = ~sys_clk;
  dtp_timer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pulse_output_pin(pulse_output_pin), .pulse_output_ch1(pulse_output_ch1),
    .irq_channel0(irq[0]), .irq_channel1(irq[1]));
  dtp_load i_load (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .level(pulse_output_pin), .high_w(high_w), .low_w(low_w));
  // Interrupt time stamps and the run limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 2; i++) begin
      if (irq[i] === 1'b1) begin
        prev_t[i] <= last_t[i];
        last_t[i] <= cyc;
        n_irq[i] <= n_irq[i] + 1;
      end
    end
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    checked++;
    if (got != exp) begin
      bad_count++;
      $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= 4'hf;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk_num(n, 1);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk_val(rd, exp);
  endtask
  // Waits for k more interrupts of one channel
  task automatic wait_irq(input int ch, input int k);
    int t;
    t = n_irq[ch] + k;
    for (int i = 0; i < 3000 && n_irq[ch] < t; i++) @(posedge sys_clk);
    chk_num(n_irq[ch] >= t, 1);
    // A missed interrupt ends the run
    if (n_irq[ch] < t) give_verdict();
  endtask
  function automatic int gap(input int ch);
    return last_t[ch] - prev_t[ch];
  endfunction
  task automatic t_reset();
    rd_chk(6'h00, 32'h0);
    rd_chk(6'h0c, 32'h0);
    rd_chk(6'h20, 32'h0);
    chk_val({31'h0, pulse_output_pin}, 32'h0);
  endtask
  // Duty 3, cycle 9, tick every clock
  task automatic t_ppg(input logic init);
    bus(1'b1, 6'h00, {init, 7'h3a});
    repeat (4) @(posedge sys_clk);
    chk_val({31'h0, pulse_output_pin}, {31'h0, init});
    bus(1'b1, 6'h08, 8'h03);
    bus(1'b1, 6'h0c, 8'h09);
    bus(1'b1, 6'h18, 8'h01);
    wait_irq(0, 3);
    chk_num(gap(0), 10);
    chk_num(high_w, init ? 4 : 6);
    chk_num(low_w, init ? 6 : 4);
    bus(1'b1, 6'h00, {!init, 7'h3a});
    rd_chk(6'h00, {24'h0, init, 7'h3a});
    bus(1'b1, 6'h18, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk_val({31'h0, pulse_output_pin}, {31'h0, init});
    bus(1'b0, 6'h1c, 8'h00);
    chk_val({24'h0, rd[7:0]}, 32'h0);
  endtask
  task automatic t_dbuf();
    bus(1'b1, 6'h00, 8'h7a);
    bus(1'b1, 6'h0c, 8'h06);
    bus(1'b1, 6'h18, 8'h01);
    wait_irq(0, 2);
    chk_num(gap(0), 7);
    bus(1'b1, 6'h0c, 8'h09);
    wait_irq(0, 1);
    chk_num(gap(0), 7);
    rd_chk(6'h0c, 32'h09);
    wait_irq(0, 1);
    chk_num(gap(0), 10);
    bus(1'b1, 6'h18, 8'h00);
  endtask
  task automatic t_nobuf();
    bus(1'b1, 6'h00, 8'h3a);
    bus(1'b1, 6'h0c, 8'h09);
    bus(1'b1, 6'h18, 8'h01);
    wait_irq(0, 1);
    bus(1'b1, 6'h0c, 8'h0c);
    wait_irq(0, 1);
    chk_num(gap(0), 13);
    bus(1'b1, 6'h0c, 8'h02);
    wait_irq(0, 1);
    chk_num(gap(0) > 200, 1);
    bus(1'b1, 6'h18, 8'h00);
  endtask
  task automatic t_and();
    bus(1'b1, 6'h04, 8'h3a);
    bus(1'b1, 6'h0c, 8'h09);
    bus(1'b1, 6'h10, 8'h05);
    bus(1'b1, 6'h14, 8'h09);
    bus(1'b1, 6'h18, 8'h0b);
    wait_irq(1, 3);
    chk_num(gap(1), 10);
    chk_num(high_w, 4);
    // Channel 1 output is high from count 7 to 9 and at count 0
    repeat (7) @(posedge sys_clk);
    chk_val({31'h0, pulse_output_ch1}, 32'h1);
    bus(1'b1, 6'h18, 8'h00);
  endtask
  task automatic t_cascade();
    int t;
    bus(1'b1, 6'h04, 8'h38);
    bus(1'b1, 6'h0c, 8'h2c);
    bus(1'b1, 6'h14, 8'h01);
    rd_chk(6'h14, 32'h01);
    bus(1'b1, 6'h18, 8'h06);
    bus(1'b1, 6'h04, 8'h3b);
    rd_chk(6'h04, 32'h38);
    t = n_irq[0];
    wait_irq(1, 2);
    chk_num(gap(1), 301);
    chk_num(n_irq[0], t);
    bus(1'b1, 6'h0c, 8'h14);
    bus(1'b1, 6'h14, 8'h00);
    wait_irq(1, 1);
    chk_num(gap(1), 21);
    bus(1'b1, 6'h18, 8'h00);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, 6'h1c, 8'h00);
    chk_val({16'h0, rd[15:0]}, 32'h0);
  endtask
  // Buffered 16-bit compare in timer mode 01
  task automatic t_cas_dbuf();
    bus(1'b1, 6'h04, 8'h79);
    bus(1'b1, 6'h0c, 8'h0a);
    bus(1'b1, 6'h14, 8'h00);
    bus(1'b1, 6'h18, 8'h06);
    wait_irq(1, 2);
    chk_num(gap(1), 11);
    bus(1'b1, 6'h0c, 8'h1e);
    bus(1'b1, 6'h14, 8'h00);
    wait_irq(1, 1);
    chk_num(gap(1), 11);
    rd_chk(6'h0c, 32'h1e);
    wait_irq(1, 1);
    chk_num(gap(1), 31);
    bus(1'b1, 6'h18, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_ppg(1'b0);
    t_ppg(1'b1);
    t_dbuf();
    t_nobuf();
    t_and();
    t_cascade();
    t_cas_dbuf();
    give_verdict();
  end
endmodule
`default_nettype wire
